// ==== logic/iopc_pkg.sv ====
package iopc_pkg;
    // ----------------------------------------------------------------
    // register offsets on the core data space
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORTA = 8'h05;
    localparam logic [7:0] ADDR_PORTB = 8'h06;
    localparam logic [7:0] ADDR_PULLDOWN = 8'h0b;
    localparam logic [7:0] ADDR_OPENDRAIN = 8'h0c;
    localparam logic [7:0] ADDR_PULLHIGH = 8'h0d;
    localparam logic [7:0] ADDR_INTMASK = 8'h0e;
    localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h0f;
    // operands of the direction-load instruction
    localparam logic [7:0] DIROP_PORTA = 8'h05;
    localparam logic [7:0] DIROP_PORTB = 8'h06;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PULLDOWN = 8'hff;
    localparam logic [7:0] RST_OPENDRAIN = 8'h00;
    localparam logic [7:0] RST_PULLHIGH = 8'hff;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;
    localparam logic RST_GIE = 1'b0;
    localparam logic [2:0] RST_IRQ_FLAG = 3'h0;
    localparam logic [6:0] RST_OPTION = 7'h3f;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [9:0] IRQ_VECTOR = 10'h008;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_GIE = 7;
    localparam int BIT_EXT = 2;
    localparam int BIT_PBC = 1;
    localparam int BIT_TMR = 0;
    localparam int OPT_EDGE = 6;
    localparam int OPT_CS = 5;
    localparam int OPT_SE = 4;
    localparam int OPT_PSA = 3;
    localparam int OPT_RATE_HI = 2;
    localparam int PD_PB_LO = 4;
    localparam int PB_INPUT_ONLY = 3;
    localparam int PB_TMR_PIN = 2;
    localparam int PB_INT_PIN = 0;
    localparam logic [7:0] MASK_FILL = 8'h78;   // unused mask bits read 1
    localparam logic [7:0] PB_PULL_VALID = 8'hf7; // pins with pull/od bits
    localparam logic [8:0] RATIO_ONE = 9'h001;
    localparam logic [8:0] RATIO_TWO = 9'h002;
endpackage

// ==== logic/iopc_top.sv ====
`timescale 1ns/10ps
module iopc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // core register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // core instructions
    input wire logic [7:0] working_register,
    input wire logic option_load,
    input wire logic direction_load_instruction,
    input wire logic [7:0] dir_operand,
    input wire logic return_from_irq,
    // core status and configuration
    input wire logic sleeping,
    input wire logic pin0_function_select,
    input wire logic [7:0] change_wake_enable,
    input wire logic [3:0] porta_alt_function,
    input wire logic [7:0] portb_alt_function,
    input wire logic timer_overflow,
    // interrupt and wake answers
    output logic irq_request,
    output logic [9:0] irq_vector,
    output logic wake_request,
    output logic wake_to_vector,
    // timer and prescaler controls
    output logic timer_tick,
    output logic timer_clock_source_select,
    output logic timer_source_edge_select,
    output logic prescaler_assign,
    output logic [2:0] prescaler_rate,
    output logic [8:0] prescale_ratio,
    // port A pins
    input wire logic [3:0] porta_in,
    output logic [3:0] porta_out,
    output logic [3:0] porta_oe,
    output logic [3:0] porta_pulldown_en,
    // port B pins
    input wire logic [7:0] portb_in,
    output logic [7:0] portb_out,
    output logic [7:0] portb_oe,
    output logic [7:0] portb_pullhigh_en,
    output logic [2:0] portb_pulldown_en
);
    import iopc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        // pin synchronisers, edge stage and change snapshot
        logic [3:0] pa_s1;
        logic [3:0] pa_s2;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic [7:0] pb_s3;
        logic [7:0] pb_snap;
        logic [1:0] arm;
        // software-visible registers
        logic [7:0] lat_a;
        logic [7:0] lat_b;
        logic [7:0] pulldown_disable;
        logic [7:0] opendrain_enable;
        logic [7:0] pullhigh_disable;
        logic global_irq_enable;
        logic [2:0] irq_en;
        logic [2:0] irq_flag;
        logic [6:0] option_cfg;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        // registered copies of the outputs
        logic [7:0] rdata;
        logic irq_req;
        logic [9:0] vector;
        logic wake;
        logic wake_vec;
        logic tick;
        logic [8:0] ratio;
        logic [3:0] pa_out;
        logic [3:0] pa_oe;
        logic [3:0] pa_pd;
        logic [7:0] pb_out;
        logic [7:0] pb_oe;
        logic [7:0] pb_ph;
        logic [2:0] pb_pd;
    } iopc_state_t;

    iopc_state_t state_ff;
    iopc_state_t nxt_state;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] dir_b_eff;
        logic [7:0] od_eff;
        logic [7:0] chg_mask;
        logic [7:0] chg;
        logic [7:0] dir_a_w;
        logic int_rise;
        logic int_fall;
        logic tmr_rise;
        logic tmr_fall;
        logic irq_pend;
        logic pb_access;
        logic armed;
        dir_b_eff = 8'h00;
        od_eff = 8'h00;
        chg_mask = 8'h00;
        chg = 8'h00;
        dir_a_w = 8'h00;
        int_rise = 1'b0;
        int_fall = 1'b0;
        tmr_rise = 1'b0;
        tmr_fall = 1'b0;
        irq_pend = 1'b0;
        pb_access = 1'b0;
        armed = 1'b0;
        nxt_state = state_ff;

        // two-stage synchronisers, third stage for edge detection
        nxt_state.pa_s1 = porta_in;
        nxt_state.pa_s2 = state_ff.pa_s1;
        nxt_state.pb_s1 = portb_in;
        nxt_state.pb_s2 = state_ff.pb_s1;
        nxt_state.pb_s3 = state_ff.pb_s2;
        // edges stay blind until three pin samples are in, so a pin that
        // idles high cannot fake a rising edge just after reset
        armed = &state_ff.arm;
        if (!armed) begin
            nxt_state.arm = state_ff.arm + 2'h1;
        end

        // effective port B direction: B3 never output, B2 follows clock src
        dir_b_eff = state_ff.port_b_direction;
        dir_b_eff[PB_INPUT_ONLY] = 1'b1;
        if (state_ff.option_cfg[OPT_CS]) begin
            dir_b_eff[PB_TMR_PIN] = 1'b1;
        end
        od_eff = state_ff.opendrain_enable & PB_PULL_VALID;

        // software register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PORTA: begin
                    nxt_state.lat_a = reg_wdata;
                end
                ADDR_PORTB: begin
                    nxt_state.lat_b = reg_wdata;
                end
                ADDR_PULLDOWN: begin
                    nxt_state.pulldown_disable = reg_wdata;
                end
                ADDR_OPENDRAIN: begin
                    nxt_state.opendrain_enable = reg_wdata;
                end
                ADDR_PULLHIGH: begin
                    nxt_state.pullhigh_disable = reg_wdata;
                end
                ADDR_INTMASK: begin
                    nxt_state.irq_en = reg_wdata[BIT_EXT:BIT_TMR];
                    nxt_state.global_irq_enable = reg_wdata[BIT_GIE];
                end
                ADDR_INTERRUPT_FLAGS: begin
                    nxt_state.irq_flag = reg_wdata[BIT_EXT:BIT_TMR];
                end
                default: ;
            endcase
        end

        // instruction loads from the working register
        if (option_load) begin
            nxt_state.option_cfg = working_register[6:0];
        end
        if (direction_load_instruction) begin
            if (dir_operand == DIROP_PORTA) begin
                nxt_state.port_a_direction = working_register;
            end else if (dir_operand == DIROP_PORTB) begin
                nxt_state.port_b_direction = working_register;
            end
        end

        // any port B access re-arms the change detector on present pins
        pb_access = (reg_wr | reg_rd) && (reg_addr == ADDR_PORTB);
        chg_mask = change_wake_enable & dir_b_eff;
        if (pin0_function_select) begin
            chg_mask[PB_INT_PIN] = 1'b0;
        end
        chg = (state_ff.pb_s2 ^ state_ff.pb_snap) & chg_mask;
        // a seen change is absorbed so it raises the flag once
        nxt_state.pb_snap = state_ff.pb_snap ^ chg;
        if (pb_access) begin
            nxt_state.pb_snap = state_ff.pb_s2;
        end

        // event flags; set wins over a software clear in the same cycle
        int_rise = armed & state_ff.pb_s2[PB_INT_PIN]
            & ~state_ff.pb_s3[PB_INT_PIN];
        int_fall = armed & ~state_ff.pb_s2[PB_INT_PIN]
            & state_ff.pb_s3[PB_INT_PIN];
        if (pin0_function_select) begin
            if (state_ff.option_cfg[OPT_EDGE] ? int_rise : int_fall) begin
                nxt_state.irq_flag[BIT_EXT] = 1'b1;
            end
        end
        if ((|chg) && state_ff.irq_en[BIT_PBC]) begin
            nxt_state.irq_flag[BIT_PBC] = 1'b1;
        end
        if (timer_overflow) begin
            nxt_state.irq_flag[BIT_TMR] = 1'b1;
        end

        // global enable: hardware clear on a taken interrupt beats all
        irq_pend = state_ff.global_irq_enable
            && (|(state_ff.irq_flag & state_ff.irq_en));
        if (irq_pend) begin
            nxt_state.global_irq_enable = 1'b0;
        end else if (return_from_irq) begin
            nxt_state.global_irq_enable = 1'b1;
        end
        nxt_state.irq_req = irq_pend;
        nxt_state.vector = IRQ_VECTOR;

        // wake from sleep on pin or change events only
        nxt_state.wake = sleeping && (|(state_ff.irq_flag[BIT_EXT:BIT_PBC]
            & state_ff.irq_en[BIT_EXT:BIT_PBC]));
        nxt_state.wake_vec = state_ff.global_irq_enable;

        // timer advance pulse from instruction clock or external pin
        tmr_rise = armed & state_ff.pb_s2[PB_TMR_PIN]
            & ~state_ff.pb_s3[PB_TMR_PIN];
        tmr_fall = armed & ~state_ff.pb_s2[PB_TMR_PIN]
            & state_ff.pb_s3[PB_TMR_PIN];
        if (state_ff.option_cfg[OPT_CS]) begin
            nxt_state.tick = state_ff.option_cfg[OPT_SE] ? tmr_fall : tmr_rise;
        end else begin
            nxt_state.tick = 1'b1;
        end

        // prescaler ratio, watchdog gets one step less division
        if (state_ff.option_cfg[OPT_PSA]) begin
            nxt_state.ratio = RATIO_ONE
                << state_ff.option_cfg[OPT_RATE_HI:0];
        end else begin
            nxt_state.ratio = RATIO_TWO
                << state_ff.option_cfg[OPT_RATE_HI:0];
        end

        // port A drivers and pull-downs
        dir_a_w = state_ff.port_a_direction;
        nxt_state.pa_out = state_ff.lat_a[3:0];
        nxt_state.pa_oe = ~dir_a_w[3:0];
        nxt_state.pa_pd = ~state_ff.pulldown_disable[3:0]
            & dir_a_w[3:0];

        // port B drivers: open-drain only releases on a one
        nxt_state.pb_out = state_ff.lat_b & ~od_eff;
        nxt_state.pb_oe = ~dir_b_eff & ~(od_eff & state_ff.lat_b);
        nxt_state.pb_ph = ~state_ff.pullhigh_disable & dir_b_eff
            & PB_PULL_VALID;
        nxt_state.pb_pd = ~state_ff.pulldown_disable[PD_PB_LO+2:PD_PB_LO]
            & dir_b_eff[2:0];

        // read data, one cycle after the strobe; unmapped reads zero
        nxt_state.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_PORTA: begin
                    nxt_state.rdata = {state_ff.lat_a[7:4],
                        state_ff.pa_s2 & ~porta_alt_function};
                end
                ADDR_PORTB: begin
                    nxt_state.rdata = state_ff.pb_s2
                        & ~portb_alt_function;
                end
                ADDR_PULLDOWN: begin
                    nxt_state.rdata = state_ff.pulldown_disable;
                end
                ADDR_OPENDRAIN: begin
                    nxt_state.rdata = state_ff.opendrain_enable;
                end
                ADDR_PULLHIGH: begin
                    nxt_state.rdata = state_ff.pullhigh_disable;
                end
                ADDR_INTMASK: begin
                    nxt_state.rdata = {state_ff.global_irq_enable, 4'h0,
                        state_ff.irq_en} | MASK_FILL;
                end
                ADDR_INTERRUPT_FLAGS: begin
                    nxt_state.rdata = {5'h00,
                        state_ff.irq_flag & state_ff.irq_en};
                end
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // pins reset as inputs with pulls off, so nothing fights the board
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= '0;
            state_ff.pb_snap <= 8'h00;
            state_ff.lat_a <= RST_LATCH;
            state_ff.lat_b <= RST_LATCH;
            state_ff.pulldown_disable <= RST_PULLDOWN;
            state_ff.opendrain_enable <= RST_OPENDRAIN;
            state_ff.pullhigh_disable <= RST_PULLHIGH;
            state_ff.global_irq_enable <= RST_GIE;
            state_ff.irq_en <= RST_IRQ_EN;
            state_ff.irq_flag <= RST_IRQ_FLAG;
            state_ff.option_cfg <= RST_OPTION;
            state_ff.port_a_direction <= RST_DIR;
            state_ff.port_b_direction <= RST_DIR;
            state_ff.vector <= IRQ_VECTOR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = state_ff.rdata;
    assign irq_request = state_ff.irq_req;
    assign irq_vector = state_ff.vector;
    assign wake_request = state_ff.wake;
    assign wake_to_vector = state_ff.wake_vec;
    assign timer_tick = state_ff.tick;
    assign timer_clock_source_select = state_ff.option_cfg[OPT_CS];
    assign timer_source_edge_select = state_ff.option_cfg[OPT_SE];
    assign prescaler_assign = state_ff.option_cfg[OPT_PSA];
    assign prescaler_rate = state_ff.option_cfg[OPT_RATE_HI:0];
    assign prescale_ratio = state_ff.ratio;
    assign porta_out = state_ff.pa_out;
    assign porta_oe = state_ff.pa_oe;
    assign porta_pulldown_en = state_ff.pa_pd;
    assign portb_out = state_ff.pb_out;
    assign portb_oe = state_ff.pb_oe;
    assign portb_pullhigh_en = state_ff.pb_ph;
    assign portb_pulldown_en = state_ff.pb_pd;
endmodule

// ==== test/iopc_board.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// board pins: driver, external source, weak pulls, else floating
// ----------------------------------------------------------------
module iopc_board #(
    parameter int W = 8
) (
    // clock
    input wire logic clk,
    // device side
    input wire logic [W-1:0] drv_out,
    input wire logic [W-1:0] drv_oe,
    input wire logic [W-1:0] pull_up,
    input wire logic [W-1:0] pull_dn,
    // outside source
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // resolved level
    output logic [W-1:0] pin
);
    logic [W-1:0] flt_ff = '0;

    // an undriven pin wanders so a stale value never reads as valid
    always_ff @(posedge clk) begin
        flt_ff <= ~flt_ff;
    end

    // device driver wins over pulls; released open-drain floats or pulls
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (drv_oe[i]) begin
                pin[i] = drv_out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pull_up[i]) begin
                pin[i] = 1'b1;
            end else if (pull_dn[i]) begin
                pin[i] = 1'b0;
            end else begin
                pin[i] = flt_ff[i];
            end
        end
    end
endmodule

// ==== test/iopc_top_properties.sv ====
`timescale 1ns/10ps
module iopc_top_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // interrupt and timer
    input wire logic irq_request,
    input wire logic timer_clock_source_select,
    input wire logic prescaler_assign,
    input wire logic [2:0] prescaler_rate,
    input wire logic [8:0] prescale_ratio,
    // pins
    input wire logic [3:0] porta_oe,
    input wire logic [3:0] porta_pulldown_en,
    input wire logic [7:0] portb_oe,
    input wire logic [7:0] portb_pullhigh_en,
    input wire logic [2:0] portb_pulldown_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_mask_fill_ones: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h0e |-> reg_rdata[6:3] == 4'hf)
        else $error("mask read spare bits not ones");
    a_flag_high_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h0f |-> reg_rdata[7:3] == 5'h00)
        else $error("flag read upper bits not zero");
    a_pullhigh_off_out: assert property (
        (portb_oe & portb_pullhigh_en) == 8'h00)
        else $error("pull-high on while driving");
    a_pulldown_off_out: assert property (
        (porta_oe & porta_pulldown_en) == 4'h0 &&
        (portb_oe[2:0] & portb_pulldown_en) == 3'h0)
        else $error("pull-down on while driving");
    a_pin3_undriven: assert property (!portb_oe[3])
        else $error("input-only pin driven");
    a_tmr_pin_input: assert property (
        timer_clock_source_select && $past(timer_clock_source_select)
        |-> !portb_oe[2])
        else $error("timer clock pin driven");
    a_irq_one_cycle: assert property (irq_request |=> !irq_request)
        else $error("interrupt request repeated");
    a_ratio_match: assert property (
        !$past(srst) && $stable(prescaler_rate) && $stable(prescaler_assign)
        |-> prescale_ratio == (prescaler_assign ? 9'h001 << prescaler_rate
                                                : 9'h002 << prescaler_rate))
        else $error("prescale ratio wrong");
endmodule

bind iopc_top iopc_top_properties i_iopc_top_properties (
    .sys_clk, .srst, .reg_addr, .reg_rd, .reg_rdata, .irq_request,
    .timer_clock_source_select, .prescaler_assign, .prescaler_rate,
    .prescale_ratio, .porta_oe, .porta_pulldown_en, .portb_oe,
    .portb_pullhigh_en, .portb_pulldown_en
);

// ==== test/iopc_top_test.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
end
module iopc_top_test;
    import iopc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic option_load = 1'b0, dir_ld = 1'b0, ret_irq = 1'b0, sleeping = 1'b0;
    logic pin0_sel = 1'b0, tmr_ovf = 1'b0, rd_q = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, work = 8'h00, r;
    logic [7:0] dir_op = 8'h00, wake_en = 8'h00, alt_b = 8'h00, exp_v;
    logic [7:0] b_ext_en = 8'h00, b_ext_val = 8'h00, reg_rdata, portb_in;
    logic [7:0] portb_out, portb_oe, portb_pullhigh_en;
    logic [3:0] porta_in, porta_out, porta_oe, porta_pulldown_en;
    logic [2:0] portb_pulldown_en;
    logic [8:0] prescale_ratio;
    logic irq_request, wake_request, timer_tick, wake_to_vector;
    logic [9:0] irq_vector;
    logic [3:0] alt_a = 4'h0;
    logic [7:0] exp_q[$];
    int seed = 32'h9647, bad_count = 0, cmp_count = 0, irq_cnt = 0, n;
    int tick_cnt = 0;

    always #4 sys_clk = ~sys_clk;

    iopc_top i_iopc_top (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .working_register(work), .option_load(option_load),
        .direction_load_instruction(dir_ld), .dir_operand(dir_op),
        .return_from_irq(ret_irq), .sleeping(sleeping),
        .pin0_function_select(pin0_sel), .change_wake_enable(wake_en),
        .porta_alt_function(alt_a), .portb_alt_function(alt_b),
        .timer_overflow(tmr_ovf), .irq_request(irq_request),
        .irq_vector(irq_vector), .wake_request(wake_request),
        .wake_to_vector(wake_to_vector),
        .timer_tick(timer_tick), .timer_clock_source_select(),
        .timer_source_edge_select(), .prescaler_assign(),
        .prescaler_rate(), .prescale_ratio(prescale_ratio),
        .porta_in(porta_in), .porta_out(porta_out), .porta_oe(porta_oe),
        .porta_pulldown_en(porta_pulldown_en), .portb_in(portb_in),
        .portb_out(portb_out), .portb_oe(portb_oe),
        .portb_pullhigh_en(portb_pullhigh_en),
        .portb_pulldown_en(portb_pulldown_en));
    iopc_board #(.W(8)) i_iopc_board (.clk(sys_clk), .drv_out(portb_out),
        .drv_oe(portb_oe), .pull_up(portb_pullhigh_en),
        .pull_dn({5'h00, portb_pulldown_en}), .ext_en(b_ext_en),
        .ext_val(b_ext_val), .pin(portb_in));
    iopc_board #(.W(4)) i_iopc_board_a (.clk(sys_clk), .drv_out(porta_out),
        .drv_oe(porta_oe), .pull_up(4'h0), .pull_dn(porta_pulldown_en),
        .ext_en(4'h0), .ext_val(4'h0), .pin(porta_in));

    // read data lands one cycle after the strobe; compare with oldest note
    always @(posedge sys_clk) begin
        rd_q <= reg_rd;
        if (irq_request === 1'b1) irq_cnt <= irq_cnt + 1;
        if (timer_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    end
    always @(negedge sys_clk) begin
        if (rd_q && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK("reg_rdata", exp_v, reg_rdata)
        end
    end

    // ----------------------------------------------------------------
    // core-side tasks: strobes rise and fall on rising edges
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic opt(input logic [6:0] v);
        @(posedge sys_clk);
        work <= {1'b0, v};
        option_load <= 1'b1;
        @(posedge sys_clk);
        option_load <= 1'b0;
    endtask
    task automatic dir(input logic [7:0] op, input logic [7:0] v);
        @(posedge sys_clk);
        work <= v;
        dir_op <= op;
        dir_ld <= 1'b1;
        @(posedge sys_clk);
        dir_ld <= 1'b0;
    endtask
    task automatic ret;
        @(posedge sys_clk);
        ret_irq <= 1'b1;
        @(posedge sys_clk);
        ret_irq <= 1'b0;
    endtask
    // settle past the edge so registered outputs are stable
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_irq(input int n0);
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            if (irq_cnt != n0) return;
        end
        bad_count++;
        wrap_up();
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        tick(2);
        `CHK("portb_oe", 8'h00, portb_oe)
        `CHK("ratio", 9'h080, prescale_ratio)
        `CHK("vector", 10'h008, irq_vector)
        rd(ADDR_PULLDOWN, RST_PULLDOWN);
        rd(ADDR_OPENDRAIN, RST_OPENDRAIN);
        rd(ADDR_PULLHIGH, RST_PULLHIGH);
        rd(ADDR_INTMASK, 8'h78);
        rd(ADDR_INTERRUPT_FLAGS, 8'h00);
        rd(8'h30, 8'h00);
        for (int i = 0; i < 3; i++) begin
            r = 8'($random(seed));
            wr(ADDR_PULLDOWN + 8'(i), r);
            rd(ADDR_PULLDOWN + 8'(i), r);
        end
        r = 8'($random(seed));
        wr(ADDR_INTMASK, r);
        rd(ADDR_INTMASK, r | 8'h78);
        wr(ADDR_PULLDOWN, 8'h00);
        wr(ADDR_PULLHIGH, 8'h05);
        wr(ADDR_OPENDRAIN, 8'h00);
        tick(3);
        `CHK("ph_in", 8'hf2, portb_pullhigh_en)
        `CHK("pd_a_in", 4'hf, porta_pulldown_en)
        `CHK("pd_b_in", 3'h7, portb_pulldown_en)
        wr(ADDR_PORTB, 8'hff);
        dir(DIROP_PORTB, 8'h00);
        dir(DIROP_PORTA, 8'h00);
        tick(3);
        `CHK("oe_b", 8'hf3, portb_oe)
        `CHK("oe_a", 4'hf, porta_oe)
        `CHK("ph_out", 4'h0, portb_pullhigh_en[7:4])
        `CHK("pd_out", 4'h0, porta_pulldown_en)
        wr(ADDR_PORTA, 8'ha5);
        alt_a <= 4'h3;
        tick(3);
        rd(ADDR_PORTA, 8'ha4);
        alt_a <= 4'h0;
        // every rate for both prescaler assignments, internal clock
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 8; k++) begin
                opt({3'b000, 1'(p), 3'(k)});
                tick(3);
                `CHK("ratio", 9'(p ? 1 : 2) << k, prescale_ratio)
            end
        end
        `CHK("tick", 1'b1, timer_tick)
        `CHK("oe_b2", 8'hf7, portb_oe)
        wr(ADDR_OPENDRAIN, 8'hf7);
        tick(3);
        `CHK("od_rel", 8'h00, portb_oe)
        wr(ADDR_PORTB, 8'h00);
        tick(3);
        `CHK("od_low", 8'hf7, portb_oe)
        `CHK("od_out", 8'h00, portb_out)
        dir(DIROP_PORTB, 8'hff);
        tick(3);
        `CHK("od_in", 8'h00, portb_oe)
        alt_b <= 8'hff;
        rd(ADDR_PORTB, 8'h00);
        alt_b <= 8'h00;
        // external pin on rising edge wakes and interrupts
        pin0_sel <= 1'b1;
        b_ext_en <= 8'h03;
        b_ext_val <= 8'h00;
        opt(7'h48);
        tick(6);
        wr(ADDR_INTERRUPT_FLAGS, 8'h00);
        wr(ADDR_INTMASK, 8'h84);
        sleeping <= 1'b1;
        n = irq_cnt;
        b_ext_val <= 8'h01;
        wait_irq(n);
        tick(1);
        `CHK("wake", 1'b1, wake_request)
        sleeping <= 1'b0;
        rd(ADDR_INTMASK, 8'h7c);
        rd(ADDR_INTERRUPT_FLAGS, 8'h04);
        wr(ADDR_INTERRUPT_FLAGS, 8'h00);
        ret();
        rd(ADDR_INTMASK, 8'hfc);
        b_ext_val <= 8'h00;
        tick(8);
        rd(ADDR_INTERRUPT_FLAGS, 8'h00);
        opt(7'h08);
        b_ext_val <= 8'h01;
        tick(8);
        n = irq_cnt;
        b_ext_val <= 8'h00;
        wait_irq(n);
        wr(ADDR_INTERRUPT_FLAGS, 8'h00);
        ret();
        // timer flag is set while masked but reads back masked
        wr(ADDR_INTMASK, 8'h00);
        tmr_ovf <= 1'b1;
        tick(1);
        tmr_ovf <= 1'b0;
        rd(ADDR_INTERRUPT_FLAGS, 8'h00);
        n = irq_cnt;
        wr(ADDR_INTMASK, 8'h81);
        wait_irq(n);
        rd(ADDR_INTERRUPT_FLAGS, 8'h01);
        wr(ADDR_INTERRUPT_FLAGS, 8'h00);
        // change detect: pin 0 excluded as interrupt input, pin 1 joins
        wr(ADDR_INTMASK, 8'h02);
        wake_en <= 8'h01;
        wr(ADDR_PORTB, 8'h00);
        b_ext_val <= 8'h01;
        tick(8);
        rd(ADDR_INTERRUPT_FLAGS, 8'h00);
        wake_en <= 8'h02;
        wr(ADDR_PORTB, 8'h00);
        sleeping <= 1'b1;
        b_ext_val <= 8'h03;
        tick(8);
        `CHK("wake_chg", 1'b1, wake_request)
        `CHK("wake_vec", 1'b0, wake_to_vector)
        sleeping <= 1'b0;
        rd(ADDR_INTERRUPT_FLAGS, 8'h02);
        // external timer clock: falling edges count, rising ones do not
        b_ext_en <= 8'h07;
        opt(7'h38);
        tick(6);
        n = tick_cnt;
        b_ext_val <= 8'h07;
        tick(6);
        b_ext_val <= 8'h03;
        tick(6);
        `CHK("ext_tick", n + 1, tick_cnt)
        tick(4);
        wrap_up();
    end
endmodule
